/* File: verif/swd_host_kicker.sv */
`timescale 1ns/1ns

// Host model: a two-cycle kick pulse every period plus one cycles.
module swd_host_kicker (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Control from the bench.
    input wire logic kick_en,
    input wire logic [11:0] period,
    // Kick pin toward the block.
    output logic watchdog_kick_pin
);
    logic [11:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // A short period keeps the block alive, a long one lets it expire.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 12'h000;
            watchdog_kick_pin <= 1'b0;
        end else begin
            cnt_q <= (kick_en && cnt_q < period) ? cnt_q + 12'h001 : 12'h000;
            watchdog_kick_pin <= kick_en && cnt_q < 12'h002;
        end
    end
endmodule // swd_host_kicker

/* File: verif/swd_watchdog_props.sv */
`timescale 1ns/1ns

// Port-level checks for the watchdog block.
module swd_watchdog_props (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Register port.
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [15:0] rdata,
    // Pins.
    input wire logic watchdog_kick_pin,
    input wire logic pg_cond_ok,
    input wire logic alert_n,
    input wire logic power_good
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////
    // Decoded writes; a status clear is a one written to the expiry bit.
    wire logic wr_int = wr_en && addr == swd_pkg::REG_WDT_INT;
    wire logic st_clr = wr_en && addr == swd_pkg::REG_STATUS && wdata[0];

    // Two cycles of margin let an expiry already in flight land first.
    sequence s_kick;
        $rose(watchdog_kick_pin) ##2 alert_n;
    endsequence
    sequence s_int_wr(bit zero);
        wr_int && ((wdata[10:0] == 11'h000) == zero) ##2 alert_n;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    AST_RD_IDLE:
        assert property (!$past(rd_en) |-> rdata == 16'h0000)
        else $error("read data not idle");
    AST_PG_COND:
        assert property (!pg_cond_ok |=> !power_good)
        else $error("power good high without its condition");
    AST_PG_HOLD:
        assert property ($rose(pg_cond_ok) |-> !power_good [*2])
        else $error("power good rose with no delay");
    AST_PG_DROP:
        assert property ($fell(power_good) |-> !$past(pg_cond_ok) || !alert_n)
        else $error("power good dropped without a cause");
    AST_ALERT_STICKY:
        assert property ($rose(alert_n) |-> $past(st_clr) || $past(st_clr, 2))
        else $error("alert released without a status clear");
    AST_KICK:
        assert property (s_kick |=> alert_n [*8])
        else $error("expiry right after a kick");
    AST_INT_WRITE:
        assert property (s_int_wr(1'b0) |=> alert_n [*8])
        else $error("expiry right after an interval write");
    AST_ZERO_WRITE:
        assert property (s_int_wr(1'b1) |=> alert_n [*8])
        else $error("expiry after the watchdog was disabled");
endmodule // swd_watchdog_props

bind swd_watchdog swd_watchdog_props u_props (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .watchdog_kick_pin(watchdog_kick_pin), .pg_cond_ok(pg_cond_ok),
    .alert_n(alert_n), .power_good(power_good)
);

/* File: verif/tb.sv */
`timescale 1ns/1ns

// Self-checking bench for the watchdog block.
module tb;
    logic clk = 1'b0, arst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic sh_clk = 1'b0, sh_en = 1'b0, pg_ok = 1'b0, kick_en = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic kick, alert_n, power_good, irq;
    int err_total = 0;
    int check_count = 0;

    // The 10 MHz clock.
    always #50 clk = ~clk;
    // Shared timebase of 10 us; it moves off the clk edge, else stands low.
    always #5000 sh_clk = sh_en ? ~sh_clk : 1'b0;

    swd_watchdog uut (
        .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .watchdog_kick_pin(kick), .shared_timebase_clock(sh_clk),
        .pg_cond_ok(pg_ok), .alert_n(alert_n), .power_good(power_good),
        .irq(irq)
    );
    swd_host_kicker host (
        .clk(clk), .arst_n(arst_n), .kick_en(kick_en),
        .period(12'h12C), .watchdog_kick_pin(kick)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    // Cycles until power good rises or alert falls must land in a window.
    task automatic span(input bit on_pg, input int lo, input int hi);
        int n;
        n = 0;
        while ((on_pg ? power_good !== 1'b1 : alert_n !== 1'b0) &&
               n <= hi) begin
            @(negedge clk);
            n++;
        end
        check(16'(n >= lo && n <= hi), 16'h0001);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Everything reads zero after reset, the unmapped place included.
    task automatic t_reset();
        for (int a = 0; a < 32; a += 4) rd(8'(a), 16'h0000);
        check({14'h0000, alert_n, power_good}, 16'h0002);
    endtask

    // Delay 0.375 ms rounds to two 200 us units, on both timebases.
    task automatic t_pg();
        wr(swd_pkg::REG_PG_DLY, 16'h7BFF);
        rd(swd_pkg::REG_PG_DLY, 16'h7BFF);
        wr(swd_pkg::REG_PG_DLY, 16'hE803);
        rd(swd_pkg::REG_PG_DLY, 16'hE803);
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            pg_ok <= 1'b0;
            sh_en <= s[0];
            repeat (500) @(posedge clk);
            pg_ok <= 1'b1;
            span(1'b1, 1900, 4100);
        end
        rd(swd_pkg::REG_STATUS, 16'h0002);
        wr(swd_pkg::REG_STATUS, 16'h0007);
    endtask

    // First interval of 1 ms, later ones of 6 units of 10 us, then off.
    task automatic t_first();
        wr(swd_pkg::REG_MASK, 16'h0001);
        wr(swd_pkg::REG_WDT_INT, 16'hE001);
        wr(swd_pkg::REG_WDT_FIRST, 16'h0001);
        span(1'b0, 9700, 10150);
        repeat (2) @(negedge clk);
        check({15'h0000, irq}, 16'h0001);
        wr(swd_pkg::REG_MASK, 16'h0000);
        repeat (2) @(negedge clk);
        check({15'h0000, irq}, 16'h0000);
        wr(swd_pkg::REG_STATUS, 16'h0001);
        repeat (2) @(negedge clk);
        span(1'b0, 480, 650);
        wr(swd_pkg::REG_WDT_INT, 16'h0000);
        wr(swd_pkg::REG_STATUS, 16'h0001);
        repeat (1500) @(negedge clk);
        check({15'h0000, alert_n}, 16'h0001);
    endtask

    // Host kicks keep it alive; so do interval writes; silence expires it.
    task automatic t_kick();
        wr(swd_pkg::REG_WDT_INT, 16'hE001);
        kick_en <= 1'b1;
        repeat (4000) @(negedge clk);
        check({15'h0000, alert_n}, 16'h0001);
        // Stop right after a kick so the silence starts at a known edge.
        @(posedge clk iff kick);
        kick_en <= 1'b0;
        span(1'b0, 250, 750);
        wr(swd_pkg::REG_STATUS, 16'h0001);
        repeat (8) begin
            wr(swd_pkg::REG_WDT_INT, 16'hE001);
            repeat (400) @(posedge clk);
        end
        check({15'h0000, alert_n}, 16'h0001);
        span(1'b0, 50, 350);
        wr(swd_pkg::REG_STATUS, 16'h0001);
        wr(swd_pkg::REG_WDT_INT, 16'h0000);
    endtask

    // Expiry drops power good, which returns after the delay.
    task automatic t_drop();
        @(posedge clk);
        pg_ok <= 1'b0;
        wr(swd_pkg::REG_CTRL, 16'h0001);
        wr(swd_pkg::REG_STATUS, 16'h0007);
        wr(swd_pkg::REG_WDT_INT, 16'hE001);
        @(posedge clk);
        pg_ok <= 1'b1;
        span(1'b1, 1900, 4100);
        span(1'b0, 9700, 10150);
        check({15'h0000, power_good}, 16'h0000);
        rd(swd_pkg::REG_STATUS, 16'h0007);
        wr(swd_pkg::REG_STATUS, 16'h0007);
        span(1'b1, 1900, 4100);
        wr(swd_pkg::REG_WDT_INT, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence after three cycles of reset.
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_pg();
        t_first();
        t_kick();
        t_drop();
        tally_and_finish();
    end

    // Cuts a hang short; the tests need about 50k cycles.
    initial begin
        #7000000;
        err_total++;
        tally_and_finish();
    end
endmodule // tb

/* File: verilog/swd_pkg.sv */
package swd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the plain register port.
    localparam logic [7:0] REG_WDT_FIRST = 8'h00;
    localparam logic [7:0] REG_WDT_INT = 8'h04;
    localparam logic [7:0] REG_PG_DLY = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_MASK = 8'h14;
    localparam logic [7:0] REG_STATE = 8'h18;

    // Reset values; zero interval values leave the watchdog disabled.
    localparam logic [15:0] RST_WDT_FIRST = 16'h0000;
    localparam logic [15:0] RST_WDT_INT = 16'h0000;
    localparam logic [15:0] RST_PG_DLY = 16'h0000;
    localparam logic RST_CTRL = 1'b0;

    // Field positions of the linear-11 word and of the event bits.
    localparam int L11_EXP_LSB = 11;
    localparam int L11_SIGN = 10;
    localparam int EV_EXPIRED = 0;
    localparam int EV_PG_UP = 1;
    localparam int EV_PG_DROP = 2;
    localparam int NUM_EV = 3;

    // Timing: clock period and the counting units of each timer.
    localparam int CLK_PERIOD_NS = 100;
    localparam int SUB_UNIT_NS = 10000;
    localparam int FIRST_UNIT_NS = 1000000;
    localparam int PG_UNIT_NS = 200000;
    localparam int SUB_UNIT_CYC = SUB_UNIT_NS / CLK_PERIOD_NS;
    localparam int FIRST_PER_SUB = FIRST_UNIT_NS / SUB_UNIT_NS;
    localparam int PG_PER_SUB = PG_UNIT_NS / SUB_UNIT_NS;
    localparam int SHR_LOSS_CYC = 4 * SUB_UNIT_CYC;

    // Units per millisecond, used by the linear-11 conversion.
    localparam logic [6:0] K_SUB = 7'(1000000 / SUB_UNIT_NS);
    localparam logic [6:0] K_FIRST = 7'(1000000 / FIRST_UNIT_NS);
    localparam logic [6:0] K_PG = 7'(1000000 / PG_UNIT_NS);

    // Upper limits in milliseconds and in counting units.
    localparam int SUB_MAX_MS = 600;
    localparam int FIRST_MAX_MS = 65000;
    localparam int PG_MAX_MS = 13100;
    localparam logic [15:0] SUB_MAX_U = 16'(SUB_MAX_MS * 100);
    localparam logic [15:0] FIRST_MAX_U = 16'(FIRST_MAX_MS * 1);
    localparam logic [15:0] PG_MAX_U = 16'(PG_MAX_MS * 5);

    ////////////////////////////////////////////////////////////////////////
    // Watchdog and power-good state machines.
    typedef enum logic [2:0] {
        W_OFF = 3'b001,
        W_FIRST = 3'b010,
        W_RUN = 3'b100
    } swd_wst_t;

    typedef enum logic [2:0] {
        P_LOW = 3'b001,
        P_WAIT = 3'b010,
        P_ON = 3'b100
    } swd_pst_t;

endpackage

/* File: verilog/swd_watchdog.sv */
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// Contract
// - A non-zero write to the interval register restarts the count.
// - Each kick pin rising edge restarts the count; host kicks in time.
// - Expiry asserts alert low, optionally drops then reasserts good.
// - Zero in either interval register disables the watchdog.
// - With good tied to watchdog, first interval follows good rising.
// - Otherwise the first interval follows the watchdog enabling.
// - After the first interval, every interval uses the later value; with good tied to watchdog, an expiry returns to the first interval.
// - Interval and delay registers hold 16-bit linear-11 milliseconds.
// - Timers run internally; later interval aligns to shared clock.
// - Later interval rounds to 10 us, first interval to 1 ms.
// - Later interval limited to 0.6 s, first interval to 65 s.
// - Good held low for the delay after condition valid, then high.
// - Delay counts on shared clock if present, else internal clock.
// - Delay clamped to 13.1 s and rounded to 200 us.
// - Delay register reads back the value last written.
module swd_watchdog (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Register port.
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rdata,
    // Pins and internal condition.
    input wire logic watchdog_kick_pin,
    input wire logic shared_timebase_clock,
    input wire logic pg_cond_ok,
    output logic alert_n,
    output logic power_good,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // All state of the block.
    typedef struct packed {
        logic [15:0] raw_first;
        logic [15:0] raw_int;
        logic [15:0] raw_pg;
        logic [15:0] u_first;
        logic [15:0] u_int;
        logic [15:0] u_pg;
        logic ctrl_pg_drop;
        logic [2:0] status;
        logic [2:0] mask;
        logic [15:0] rdata;
        swd_pkg::swd_wst_t wst;
        swd_pkg::swd_pst_t pst;
        logic [15:0] wcnt;
        logic [15:0] pcnt;
        logic [6:0] pre;
        logic [6:0] ms;
        logic [4:0] pgdiv;
        logic [9:0] shr_age;
        logic shr_prev;
        logic kick_prev;
        logic pg;
        logic pg_prev;
        logic alert_n;
        logic irq;
    } swd_state_t;

    swd_state_t s_q;
    swd_state_t s_d;

    logic kick_rise;
    logic shr_edge;
    logic shr_run;
    logic int_tick;
    logic ms_tick;
    logic sub_tick;
    logic pg_base;
    logic pg_tick;
    logic wdt_en;
    logic restart;
    logic pg_rise;
    logic wdt_exp;
    logic [2:0] ev;
    ////////////////////////////////////////////////////////////////////////
    // Linear-11 milliseconds to counting units, rounded to nearest and
    // clamped. A negative or tiny value becomes one unit so that only a
    // true zero mantissa disables the timer.
    function automatic logic [15:0] l11_units(input logic [15:0] v,
                                              input logic [6:0] k,
                                              input logic [15:0] lim);
        logic [4:0] n;
        logic [4:0] sh;
        logic [39:0] p;
        logic [39:0] r;
        begin
            n = v[15:swd_pkg::L11_EXP_LSB];
            sh = 5'h00 - n;
            p = 40'(v[9:0]) * 40'(k);
            if (v[swd_pkg::L11_SIGN]) begin
                r = 40'h1;
            end else if (!n[4]) begin
                r = p << n[3:0];
            end else begin
                r = (p + (40'h1 << (sh - 5'h01))) >> sh;
            end
            if (r > 40'(lim)) begin
                r = 40'(lim);
            end
            if (r == 40'h0 && v[10:0] != 11'h000) begin
                r = 40'h1;
            end
            return r[15:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin edges and timebase ticks. Inputs are synchronous to clk.
    assign kick_rise = watchdog_kick_pin & ~s_q.kick_prev;
    assign shr_edge = shared_timebase_clock & ~s_q.shr_prev;
    assign shr_run = s_q.shr_age < 10'(swd_pkg::SHR_LOSS_CYC);
    assign int_tick = s_q.pre == 7'(swd_pkg::SUB_UNIT_CYC - 1);
    assign ms_tick = int_tick &&
                     s_q.ms == 7'(swd_pkg::FIRST_PER_SUB - 1);
    // Later intervals follow the shared clock while it runs.
    assign sub_tick = shr_run ? shr_edge : int_tick;
    assign pg_base = shr_run ? shr_edge : int_tick;
    assign pg_tick = pg_base &&
                     s_q.pgdiv == 5'(swd_pkg::PG_PER_SUB - 1);

    // Enable needs both mantissas non-zero.
    assign wdt_en = (s_q.raw_first[10:0] != 11'h000) &&
                    (s_q.raw_int[10:0] != 11'h000);
    assign restart = kick_rise || (wr_en && addr == swd_pkg::REG_WDT_INT &&
                     wdata != 16'h0000);
    assign pg_rise = s_q.pg & ~s_q.pg_prev;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole block.
    always_comb begin
        s_d = s_q;
        wdt_exp = 1'b0;
        ev = 3'b000;
        s_d.kick_prev = watchdog_kick_pin;
        s_d.shr_prev = shared_timebase_clock;
        s_d.pg_prev = s_q.pg;

        // Free internal prescalers; the shared clock watchdog is a
        // saturating age counter so a stopped clock falls back cleanly.
        s_d.pre = int_tick ? 7'h00 : s_q.pre + 7'h01;
        if (int_tick) begin
            s_d.ms = ms_tick ? 7'h00 : s_q.ms + 7'h01;
        end
        if (pg_base) begin
            s_d.pgdiv = pg_tick ? 5'h00 : s_q.pgdiv + 5'h01;
        end
        if (shr_edge) begin
            s_d.shr_age = 10'h000;
        end else if (shr_run) begin
            s_d.shr_age = s_q.shr_age + 10'h001;
        end

        // Register writes store raw values and convert them to units.
        if (wr_en) begin
            unique case (addr)
                swd_pkg::REG_WDT_FIRST: begin
                    s_d.raw_first = wdata;
                    s_d.u_first = l11_units(wdata, swd_pkg::K_FIRST,
                        swd_pkg::FIRST_MAX_U);
                end
                swd_pkg::REG_WDT_INT: begin
                    s_d.raw_int = wdata;
                    s_d.u_int = l11_units(wdata, swd_pkg::K_SUB,
                        swd_pkg::SUB_MAX_U);
                end
                swd_pkg::REG_PG_DLY: begin
                    s_d.raw_pg = wdata;
                    s_d.u_pg = l11_units(wdata, swd_pkg::K_PG,
                        swd_pkg::PG_MAX_U);
                end
                swd_pkg::REG_CTRL: s_d.ctrl_pg_drop = wdata[0];
                swd_pkg::REG_MASK: s_d.mask = wdata[2:0];
                swd_pkg::REG_STATUS: s_d.status = s_q.status & ~wdata[2:0];
                default: ;
            endcase
        end

        // Watchdog state machine. Starting a first interval rephases the
        // 1 ms divider, else the first unit could be up to 1 ms short.
        unique case (s_q.wst)
            swd_pkg::W_OFF: begin
                if (wdt_en && (s_q.ctrl_pg_drop ? pg_rise : 1'b1)) begin
                    s_d.wst = swd_pkg::W_FIRST;
                    s_d.wcnt = s_q.u_first;
                    s_d.pre = 7'h00;
                    s_d.ms = 7'h00;
                end
            end
            swd_pkg::W_FIRST: begin
                if (restart) begin
                    s_d.wst = swd_pkg::W_RUN;
                    s_d.wcnt = s_q.u_int;
                end else if (ms_tick) begin
                    if (s_q.wcnt <= 16'h0001) begin
                        wdt_exp = 1'b1;
                    end else begin
                        s_d.wcnt = s_q.wcnt - 16'h0001;
                    end
                end
            end
            swd_pkg::W_RUN: begin
                if (restart) begin
                    s_d.wcnt = s_q.u_int;
                end else if (sub_tick) begin
                    if (s_q.wcnt <= 16'h0001) begin
                        wdt_exp = 1'b1;
                    end else begin
                        s_d.wcnt = s_q.wcnt - 16'h0001;
                    end
                end
            end
        endcase

        // Expiry either waits for good to return or keeps running.
        if (wdt_exp) begin
            if (s_q.ctrl_pg_drop) begin
                s_d.wst = swd_pkg::W_OFF;
            end else begin
                s_d.wst = swd_pkg::W_RUN;
                s_d.wcnt = s_q.u_int;
            end
        end
        if (!wdt_en) begin
            s_d.wst = swd_pkg::W_OFF;
        end

        // Power-good state machine with its assertion delay.
        unique case (s_q.pst)
            swd_pkg::P_LOW: begin
                if (pg_cond_ok) begin
                    s_d.pst = (s_q.u_pg == 16'h0000) ? swd_pkg::P_ON :
                              swd_pkg::P_WAIT;
                    s_d.pcnt = s_q.u_pg;
                end
            end
            swd_pkg::P_WAIT: begin
                if (pg_tick) begin
                    if (s_q.pcnt <= 16'h0001) begin
                        s_d.pst = swd_pkg::P_ON;
                    end else begin
                        s_d.pcnt = s_q.pcnt - 16'h0001;
                    end
                end
            end
            swd_pkg::P_ON: ;
        endcase
        // Dropping on expiry reuses the delay before reasserting.
        if (wdt_exp && s_q.ctrl_pg_drop) begin
            s_d.pst = swd_pkg::P_WAIT;
            s_d.pcnt = s_q.u_pg;
        end
        if (!pg_cond_ok) begin
            s_d.pst = swd_pkg::P_LOW;
        end
        s_d.pg = s_d.pst == swd_pkg::P_ON;

        // Sticky events; a set in the clearing cycle wins.
        ev[swd_pkg::EV_EXPIRED] = wdt_exp;
        ev[swd_pkg::EV_PG_UP] = s_d.pg & ~s_q.pg;
        ev[swd_pkg::EV_PG_DROP] = wdt_exp & s_q.ctrl_pg_drop;
        s_d.status = s_d.status | ev;
        s_d.alert_n = ~s_d.status[swd_pkg::EV_EXPIRED];
        s_d.irq = |(s_d.status & s_d.mask);

        // Read data stand only in the cycle after the strobe.
        s_d.rdata = 16'h0000;
        if (rd_en) begin
            unique case (addr)
                swd_pkg::REG_WDT_FIRST: s_d.rdata = s_q.raw_first;
                swd_pkg::REG_WDT_INT: s_d.rdata = s_q.raw_int;
                swd_pkg::REG_PG_DLY: s_d.rdata = s_q.raw_pg;
                swd_pkg::REG_CTRL: s_d.rdata = {15'h0000, s_q.ctrl_pg_drop};
                swd_pkg::REG_STATUS: s_d.rdata = {13'h0000, s_q.status};
                swd_pkg::REG_MASK: s_d.rdata = {13'h0000, s_q.mask};
                swd_pkg::REG_STATE: begin
                    s_d.rdata = {12'h000, shr_run,
                                 s_q.wst != swd_pkg::W_OFF,
                                 ~s_q.alert_n, s_q.pg};
                end
                default: s_d.rdata = 16'h0000;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // State register. Reset holds constants only.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{
                raw_first: swd_pkg::RST_WDT_FIRST,
                raw_int: swd_pkg::RST_WDT_INT,
                raw_pg: swd_pkg::RST_PG_DLY,
                u_first: 16'h0000,
                u_int: 16'h0000,
                u_pg: 16'h0000,
                ctrl_pg_drop: swd_pkg::RST_CTRL,
                status: 3'h0,
                mask: 3'h0,
                rdata: 16'h0000,
                wst: swd_pkg::W_OFF,
                pst: swd_pkg::P_LOW,
                wcnt: 16'h0000,
                pcnt: 16'h0000,
                pre: 7'h00,
                ms: 7'h00,
                pgdiv: 5'h00,
                shr_age: 10'h3FF,
                shr_prev: 1'b0,
                kick_prev: 1'b0,
                pg: 1'b0,
                pg_prev: 1'b0,
                alert_n: 1'b1,
                irq: 1'b0
            };
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from the state register.
    assign rdata = s_q.rdata;
    assign alert_n = s_q.alert_n;
    assign power_good = s_q.pg;
    assign irq = s_q.irq;

endmodule // swd_watchdog
